// ===== bench/qsp_peer.sv
// remote serial equipment model: loopback cable plus handshake line generation
`timescale 1ns/1ps
`default_nettype none
module qsp_peer (
   input  wire logic [3:0] TXD,
   input  wire logic [3:0] RTS_N,
   input  wire logic [3:0] READY,
   output logic      [3:0] RXD,
   output logic      [3:0] CTS_N,
   output logic      [3:0] DCD_N,
   output logic      [3:0] RTS_LINE,
   output logic      [3:0] DTR_LINE
);
   // data loops back; a port whose remote is not ready shows an idle mark line
   assign RXD      = TXD | ~READY;
   assign CTS_N    = ~READY;
   assign DCD_N    = ~READY;
   assign RTS_LINE = ~RTS_N;
   assign DTR_LINE = 4'hf;
endmodule
`default_nettype wire

// ===== bench/quad_serial_port_handshake_tb_top.sv
// self-checking bench of the quad serial port block with a loopback peer
`timescale 1ns/1ps
`default_nettype none
module quad_serial_port_handshake_tb_top;
   localparam logic [15:0] B = 16'h8340;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  ready = 4'h1;
   logic [2:0]  jumper = 3'h0;
   logic [31:0] avs_readdata, rdata;
   logic        waitreq;
   logic [6:0]  irq_lines;
   logic [3:0]  txd, rxd, cts_n, dcd_n, rts_n, tx_led, rx_led;
   int          err_total = 0;
   int          n_compared = 0;
   int          cyc = 0;
   qsp_top dut (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(waitreq),
      .BOARD_ADDRESS_SWITCH(2'h0), .BLOCK_BASE_SWITCH(2'h3), .RATE_SELECT_SWITCH(24'h041041),
      .INTERRUPT_LEVEL_JUMPER(jumper), .IRQ_LINES(irq_lines), .TXD(txd), .RXD(rxd),
      .CTS_N(cts_n), .DCD_N(dcd_n), .RTS_N(rts_n), .TX_LED(tx_led), .RX_LED(rx_led));
   qsp_peer peer (.TXD(txd), .RTS_N(rts_n), .READY(ready), .RXD(rxd), .CTS_N(cts_n),
      .DCD_N(dcd_n), .RTS_LINE(), .DTR_LINE());
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one avalon cycle held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clock); while (waitreq !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // polls a port's status until a byte has arrived; bounded so a hang cannot last
   task automatic wait_rx(input int p);
      for (int i = 0; i < 10000; i++) begin
         bus(1'b0, B + 16'(p * 16) + 16'h4, 32'h0);
         if (rdata[0] === 1'b1) break;
      end
   endtask
   task automatic t_rts();
      logic [3:0] e;
      e = 4'hf;
      for (int p = 0; p < 4; p++) begin
         // divide by 16 gives mid-bit sampling; port 1 runs seven bits, even parity
         bus(1'b1, B + 16'(p * 16), (p == 1) ? 32'h29 : 32'h25);
         e[p] = 1'b0;
         @(negedge clock);
         chk({28'h0, rts_n}, {28'h0, e});
      end
      $display("rts test done");
   endtask
   task automatic t_loop();
      bus(1'b1, B + 16'h44, 32'h1);
      bus(1'b1, B + 16'h8, 32'ha5);
      // the start bit lights both indicators through the loopback
      for (int i = 0; i < 4000 && tx_led[0] !== 1'b1; i++) @(negedge clock);
      chk({30'h0, tx_led[0], rx_led[0]}, 32'h3);
      wait_rx(0);
      chk(rdata, 32'hf);
      chk({25'h0, irq_lines}, 32'h0);
      jumper <= 3'h3;
      @(negedge clock);
      chk({25'h0, irq_lines}, 32'h4);
      @(posedge clock);
      jumper <= 3'h1;
      @(negedge clock);
      chk({25'h0, irq_lines}, 32'h1);
      bus(1'b0, B + 16'h8, 32'h0);
      chk(rdata, 32'ha5);
      bus(1'b1, B + 16'h40, 32'hfff);
      @(negedge clock);
      chk({25'h0, irq_lines}, 32'h0);
      $display("loopback test done");
   endtask
   task automatic t_gate();
      int lows;
      lows = 0;
      bus(1'b0, B + 16'h14, 32'h0);
      chk(rdata, 32'h2);
      bus(1'b0, B + 16'h4, 32'h0);
      chk(rdata, 32'he);
      bus(1'b1, B + 16'h18, 32'h3c);
      repeat (1500) begin
         @(negedge clock);
         if (txd[1] !== 1'b1) lows++;
      end
      chk(lows, 0);
      @(posedge clock);
      ready <= 4'h3;
      wait_rx(1);
      chk(rdata, 32'hf);
      bus(1'b0, B + 16'h18, 32'h0);
      chk(rdata, 32'h3c);
      $display("gating test done");
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard: the whole run needs well under this many cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      t_rts();
      t_loop();
      t_gate();
      test_done();
   end
endmodule
`default_nettype wire

// ===== common/qsp_pkg.sv
// constants, field layouts and state types of the quad serial port block
package qsp_pkg;
   localparam int NUM_PORTS = 4;
   localparam int RATE_TAPS = 6;
   localparam int CTRL_W    = 6;
   localparam int STAT_W    = 7;
   localparam int EV_W      = 3;
   // block placement: base plus block switch times step plus board switch times step
   localparam logic [15:0] BLOCK_BASE  = 16'h8040;
   localparam logic [15:0] BLOCK_SPAN  = 16'h0048;
   // register offsets inside the block, adapter p at p * 16'h0010
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STAT     = 8'h04;
   localparam logic [7:0] OFF_DATA     = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
   // control register fields
   localparam int CTRL_DIV_LSB = 0;
   localparam int CTRL_WL8     = 2;
   localparam int CTRL_PAR_LSB = 3;
   localparam int CTRL_RTS     = 5;
   localparam logic [5:0] CTRL_RST = 6'h03;
   localparam logic [1:0] DIV_1     = 2'h0;
   localparam logic [1:0] DIV_16    = 2'h1;
   localparam logic [1:0] DIV_64    = 2'h2;
   localparam logic [1:0] DIV_RESET = 2'h3;
   localparam logic [1:0] PAR_NONE  = 2'h0;
   localparam logic [1:0] PAR_EVEN  = 2'h1;
   localparam logic [1:0] PAR_ODD   = 2'h2;
   // status register bits
   localparam int ST_RX_FULL  = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_DCD      = 2;
   localparam int ST_CTS      = 3;
   localparam int ST_FRAME    = 4;
   localparam int ST_OVERRUN  = 5;
   localparam int ST_PARITY   = 6;
   // event bits, three per port in the interrupt status register
   localparam int EV_RX  = 0;
   localparam int EV_TX  = 1;
   localparam int EV_ERR = 2;
   localparam logic [11:0] IRQ_RST = 12'h000;
   // crystal rate made from the system clock by a phase accumulator
   localparam logic [26:0] CLK_HZ  = 27'd100000000;
   localparam logic [26:0] XTAL_HZ = 27'd1843200;
   typedef enum logic [1:0] {QSP_TX_IDLE = 2'b01, QSP_TX_SHIFT = 2'b10} qsp_tx_state_type;
   typedef enum logic [1:0] {QSP_RX_IDLE = 2'b01, QSP_RX_BITS = 2'b10} qsp_rx_state_type;
endpackage

// ===== common/qsp_port_if.sv
// per-port carrier between the register block and one serial adapter
`timescale 1ns/1ps
`default_nettype none
interface qsp_port_if;
   logic        ref_tick;
   logic [5:0]  ctrl;
   logic        tx_wr;
   logic [7:0]  tx_byte;
   logic        rx_rd;
   logic [7:0]  rx_byte;
   logic [6:0]  status;
   logic [2:0]  events;
   modport ctl (output ref_tick, ctrl, tx_wr, tx_byte, rx_rd,
                input  rx_byte, status, events);
   modport adp (input  ref_tick, ctrl, tx_wr, tx_byte, rx_rd,
                output rx_byte, status, events);
endinterface
`default_nettype wire

// ===== hdl/qsp_adapter.sv
// one asynchronous serial adapter: rate divider, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module qsp_adapter (
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire logic     ce,
   qsp_port_if.adp       bus,
   output logic          txd,
   input  wire logic     rxd,
   input  wire logic     cts_n,
   input  wire logic     dcd_n
);
   qsp_pkg::qsp_tx_state_type tx_state_reg;
   qsp_pkg::qsp_rx_state_type rx_state_reg;
   logic [1:0]  div;
   logic [1:0]  par;
   logic        wl8, pen, clr, rx_en, tx_tick, tx_load, rx_done, rx_take, perr;
   logic [5:0]  ratio_m1, tx_cnt_reg, rx_cnt_reg;
   logic [7:0]  hold_reg, dm, rx_byte_reg, rx_data;
   logic        hold_full_reg, rx_full_reg, frame_reg, ovr_reg, perr_reg;
   logic [10:0] tx_sh_reg, frame;
   logic [3:0]  tx_left_reg, rx_pos_reg, nb, last;
   logic [9:0]  rx_sh_reg;

   assign div   = bus.ctrl[qsp_pkg::CTRL_DIV_LSB +: 2];
   assign par   = bus.ctrl[qsp_pkg::CTRL_PAR_LSB +: 2];
   assign wl8   = bus.ctrl[qsp_pkg::CTRL_WL8];
   assign pen   = (par != qsp_pkg::PAR_NONE);
   assign clr   = rst || (ce && div == qsp_pkg::DIV_RESET);
   assign rx_en = !cts_n && !dcd_n;
   assign nb    = wl8 ? 4'd8 : 4'd7;
   assign last  = 4'(nb + {3'b000, pen} + 4'd1);

   // divide the reference tick by the programmed ratio
   always_comb begin
      case (div)
         qsp_pkg::DIV_16: ratio_m1 = 6'h0f;
         qsp_pkg::DIV_64: ratio_m1 = 6'h3f;
         default:         ratio_m1 = 6'h00;
      endcase
   end
   assign tx_tick = bus.ref_tick && (tx_cnt_reg == ratio_m1);

   // free-running transmit phase, a queued byte waits at most one bit time
   always_ff @(posedge clk) begin
      if (clr)
         tx_cnt_reg <= 6'h00;
      else if (ce && bus.ref_tick)
         tx_cnt_reg <= tx_tick ? 6'h00 : 6'(tx_cnt_reg + 6'h01);
   end

   // frame: start bit, data lsb first, optional parity, one stop bit
   always_comb begin
      dm    = wl8 ? hold_reg : {1'b0, hold_reg[6:0]};
      frame = wl8 ? {1'b1, pen ? (^dm ^ (par == qsp_pkg::PAR_ODD)) : 1'b1, dm, 1'b0}
                  : {2'b11, pen ? (^dm ^ (par == qsp_pkg::PAR_ODD)) : 1'b1, dm[6:0], 1'b0};
   end
   // sending starts only while clear-to-send is low; a started frame completes
   assign tx_load = (tx_state_reg == qsp_pkg::QSP_TX_IDLE) && hold_full_reg && !cts_n;

   // holding register, a write in the loading cycle keeps it full
   always_ff @(posedge clk) begin
      if (clr) begin
         hold_reg      <= 8'h00;
         hold_full_reg <= 1'b0;
      end else if (ce) begin
         if (bus.tx_wr) begin
            hold_reg      <= bus.tx_byte;
            hold_full_reg <= 1'b1;
         end else if (tx_load)
            hold_full_reg <= 1'b0;
      end
   end

   // transmit shifter
   always_ff @(posedge clk) begin
      if (clr) begin
         tx_state_reg <= qsp_pkg::QSP_TX_IDLE;
         tx_sh_reg    <= 11'h7ff;
         tx_left_reg  <= 4'h0;
         txd          <= 1'b1;
      end else if (ce) begin
         case (tx_state_reg)
            qsp_pkg::QSP_TX_IDLE: begin
               if (tx_load) begin
                  tx_sh_reg    <= frame;
                  tx_left_reg  <= 4'(nb + {3'b000, pen} + 4'd2);
                  tx_state_reg <= qsp_pkg::QSP_TX_SHIFT;
               end
            end
            qsp_pkg::QSP_TX_SHIFT: begin
               if (tx_tick && tx_left_reg == 4'h0) begin
                  txd          <= 1'b1;
                  tx_state_reg <= qsp_pkg::QSP_TX_IDLE;
               end else if (tx_tick) begin
                  txd         <= tx_sh_reg[0];
                  tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
                  tx_left_reg <= 4'(tx_left_reg - 4'h1);
               end
            end
            default: tx_state_reg <= qsp_pkg::QSP_TX_IDLE;
         endcase
      end
   end

   // receiver samples mid-bit; losing either gate drops the character
   assign rx_take = bus.ref_tick && (rx_state_reg == qsp_pkg::QSP_RX_BITS)
                    && (rx_cnt_reg == 6'h00);
   assign rx_done = rx_en && rx_take && (rx_pos_reg == last);
   assign rx_data = wl8 ? rx_sh_reg[8:1] : {1'b0, rx_sh_reg[7:1]};
   assign perr    = pen && ((^rx_data ^ (wl8 ? rx_sh_reg[9] : rx_sh_reg[8]))
                            != (par == qsp_pkg::PAR_ODD));
   always_ff @(posedge clk) begin
      if (clr) begin
         rx_state_reg <= qsp_pkg::QSP_RX_IDLE;
         rx_cnt_reg   <= 6'h00;
         rx_pos_reg   <= 4'h0;
         rx_sh_reg    <= 10'h000;
      end else if (ce) begin
         case (rx_state_reg)
            qsp_pkg::QSP_RX_IDLE: begin
               if (bus.ref_tick && !rxd && rx_en) begin
                  rx_cnt_reg   <= {1'b0, ratio_m1[5:1]};
                  rx_pos_reg   <= 4'h0;
                  rx_state_reg <= qsp_pkg::QSP_RX_BITS;
               end
            end
            qsp_pkg::QSP_RX_BITS: begin
               if (!rx_en)
                  rx_state_reg <= qsp_pkg::QSP_RX_IDLE;
               else if (rx_take) begin
                  rx_cnt_reg <= ratio_m1;
                  if ((rx_pos_reg == 4'h0 && rxd) || rx_pos_reg == last)
                     rx_state_reg <= qsp_pkg::QSP_RX_IDLE;
                  else begin
                     rx_sh_reg[rx_pos_reg] <= rxd;
                     rx_pos_reg <= 4'(rx_pos_reg + 4'h1);
                  end
               end else if (bus.ref_tick)
                  rx_cnt_reg <= 6'(rx_cnt_reg - 6'h01);
            end
            default: rx_state_reg <= qsp_pkg::QSP_RX_IDLE;
         endcase
      end
   end

   // received byte and flags; a new character beats the read that clears them
   always_ff @(posedge clk) begin
      if (clr) begin
         rx_byte_reg <= 8'h00;
         rx_full_reg <= 1'b0;
         frame_reg   <= 1'b0;
         ovr_reg     <= 1'b0;
         perr_reg    <= 1'b0;
      end else if (ce) begin
         if (rx_done && rx_full_reg && !bus.rx_rd)
            ovr_reg <= 1'b1; // old byte kept, the newer one is lost
         else if (rx_done) begin
            rx_byte_reg <= rx_data;
            rx_full_reg <= 1'b1;
            frame_reg   <= !rxd;
            perr_reg    <= perr;
            ovr_reg     <= 1'b0;
         end else if (bus.rx_rd) begin
            rx_full_reg <= 1'b0;
            frame_reg   <= 1'b0;
            ovr_reg     <= 1'b0;
            perr_reg    <= 1'b0;
         end
      end
   end

   assign bus.rx_byte = rx_byte_reg;
   assign bus.status  = {perr_reg, ovr_reg, frame_reg, !cts_n, !dcd_n, !hold_full_reg,
                         rx_full_reg};
   assign bus.events[qsp_pkg::EV_RX]  = ce && rx_done && (!rx_full_reg || bus.rx_rd);
   assign bus.events[qsp_pkg::EV_TX]  = ce && tx_load;
   assign bus.events[qsp_pkg::EV_ERR] = ce && rx_done
                                        && (!rxd || perr || (rx_full_reg && !bus.rx_rd));

   default clocking @(posedge clk); endclocking
   default disable iff (clr);
   tx_gate_a: assert property ($rose(tx_state_reg == qsp_pkg::QSP_TX_SHIFT) |-> $past(!cts_n))
      else $error("transmit began without clear-to-send");
   rx_gate_a: assert property ((rx_state_reg == qsp_pkg::QSP_RX_BITS) && $past(ce) && $past(rx_state_reg == qsp_pkg::QSP_RX_BITS) |-> $past(rx_en))
      else $error("receiver kept a character after a gate dropped");
   tx_idle_a: assert property ((tx_state_reg == qsp_pkg::QSP_TX_IDLE) |-> txd)
      else $error("transmit line not at mark while idle");
   rx_full_a: assert property (bus.events[qsp_pkg::EV_RX] |=> bus.status[qsp_pkg::ST_RX_FULL] ##0 bus.rx_byte == $past(rx_data))
      else $error("received byte not presented");
endmodule
`default_nettype wire

// ===== hdl/qsp_top.sv
// quad serial port block: bus slave, address decode, reference divider, four adapters
//
// Summary of operation
// - bytes written are sent serially; received serial bits become readable bytes
// - block base set by two switch bits and board switch, 8040h to 8F40h
// - crystal rate divided into taps; one of six switch positions feeds each port
// - each adapter divides its reference again by a programmed ratio
// - software programs word length, parity and divide ratio; adapter obeys it
// - active-low request-to-send follows only the software control bit
// - start a frame only while clear-to-send low, receive only while carrier-detect low
// - remote clear or ready false: incoming data dropped; clear false also stops a new frame starting
// - each port is terminal equipment: drives data and request, receives the rest
// - interrupt goes out on the jumper-chosen level, or nowhere when none chosen
// - per port, one activity indicator for transmit data, one for receive data
// - adapter, rate select, handshake and indicators per port; decode, divider shared
`timescale 1ns/1ps
`default_nettype none
module qsp_top #(
   parameter int NUM_PORTS  = qsp_pkg::NUM_PORTS,
   parameter int IRQ_LEVELS = 7
) (
   input  wire logic                        CLOCK,
   input  wire logic                        SYS_RST,
   input  wire logic                        CLK_EN,
   input  wire logic [15:0]                 AVS_ADDRESS,
   input  wire logic                        AVS_READ,
   input  wire logic                        AVS_WRITE,
   input  wire logic [31:0]                 AVS_WRITEDATA,
   input  wire logic [3:0]                  AVS_BYTEENABLE,
   output logic      [31:0]                 AVS_READDATA,
   output logic                             AVS_WAITREQUEST,
   input  wire logic [1:0]                  BOARD_ADDRESS_SWITCH,
   input  wire logic [1:0]                  BLOCK_BASE_SWITCH,
   input  wire logic [NUM_PORTS*6-1:0]      RATE_SELECT_SWITCH,
   input  wire logic [2:0]                  INTERRUPT_LEVEL_JUMPER,
   output logic      [IRQ_LEVELS-1:0]       IRQ_LINES,
   output logic      [NUM_PORTS-1:0]        TXD,
   input  wire logic [NUM_PORTS-1:0]        RXD,
   input  wire logic [NUM_PORTS-1:0]        CTS_N,
   input  wire logic [NUM_PORTS-1:0]        DCD_N,
   output logic      [NUM_PORTS-1:0]        RTS_N,
   output logic      [NUM_PORTS-1:0]        TX_LED,
   output logic      [NUM_PORTS-1:0]        RX_LED
);
   // decode and interrupt layout are laid out for at most four ports and seven levels
   if (NUM_PORTS < 1 || NUM_PORTS > 4 || IRQ_LEVELS < 1 || IRQ_LEVELS > 7) begin : g_bad
      $error("qsp_top: NUM_PORTS must be 1..4 and IRQ_LEVELS 1..7");
   end

   qsp_port_if port_bus[NUM_PORTS] ();

   logic [26:0] xtal_acc_reg, xtal_sum;
   logic        xtal_tick;
   logic [5:0]  tap_cnt_reg, tap_rise;
   logic        req, ack_reg, done, hit, port_hit, irq_any;
   logic [15:0] base, off;
   logic [1:0]  pidx;
   logic [7:0]  roff;
   logic [31:0] rd_mux, rdata_reg, wmask;
   logic [11:0] irq_stat_reg, irq_mask_reg, ev_all;
   logic [5:0]  ctrl_reg [NUM_PORTS];
   logic [NUM_PORTS-1:0] tick;
   logic [6:0]  stat_all [NUM_PORTS];
   logic [7:0]  rxb_all [NUM_PORTS];

   // reference divider shared by all ports: crystal rate from the system clock
   assign xtal_sum  = 27'(xtal_acc_reg + qsp_pkg::XTAL_HZ);
   assign xtal_tick = (xtal_sum >= qsp_pkg::CLK_HZ);
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         xtal_acc_reg <= 27'h0000000;
         tap_cnt_reg  <= 6'h00;
      end else if (CLK_EN) begin
         xtal_acc_reg <= xtal_tick ? 27'(xtal_sum - qsp_pkg::CLK_HZ) : xtal_sum;
         if (xtal_tick)
            tap_cnt_reg <= 6'(tap_cnt_reg + 6'h01);
      end
   end
   // tap k is a square wave at the crystal rate over 2^(k+1); tick on its rising edge
   assign tap_rise = xtal_tick ? (6'(tap_cnt_reg + 6'h01) & ~tap_cnt_reg) : 6'h00;

   // bus slave: one wait state, read data registered in the waiting cycle
   assign req             = AVS_READ || AVS_WRITE;
   assign AVS_WAITREQUEST = req && !(ack_reg && CLK_EN);
   assign done            = req && ack_reg && CLK_EN;
   assign AVS_READDATA    = rdata_reg;
   assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   // block base from the two switch groups; both at zero gives 16'h8040
   assign base     = 16'(qsp_pkg::BLOCK_BASE + {4'h0, BOARD_ADDRESS_SWITCH, BLOCK_BASE_SWITCH, 8'h00});
   assign off      = 16'(AVS_ADDRESS - base);
   assign hit      = (off < qsp_pkg::BLOCK_SPAN) && (AVS_ADDRESS[1:0] == 2'b00);
   assign roff     = off[7:0];
   assign pidx     = roff[5:4];
   assign port_hit = hit && !roff[6] && ({30'h0, pidx} < NUM_PORTS) && (roff[3:0] != 4'hc);

   // read multiplexer; unmapped words read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      if (port_hit) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (pidx == 2'(p)) begin
               case ({4'h0, roff[3:0]})
                  qsp_pkg::OFF_CTRL: rd_mux = {26'h0, ctrl_reg[p]};
                  qsp_pkg::OFF_STAT: rd_mux = {25'h0, stat_all[p]};
                  // held byte is captured here; the pop lands at the completing edge
                  qsp_pkg::OFF_DATA: rd_mux = {24'h0, rxb_all[p]};
                  default:           rd_mux = 32'h00000000;
               endcase
            end
         end
      end else if (hit && roff == qsp_pkg::OFF_IRQ_STAT)
         rd_mux = {20'h0, irq_stat_reg};
      else if (hit && roff == qsp_pkg::OFF_IRQ_MASK)
         rd_mux = {20'h0, irq_mask_reg};
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else if (CLK_EN) begin
         ack_reg <= req && !ack_reg;
         if (req && !ack_reg)
            rdata_reg <= AVS_READ ? rd_mux : 32'h00000000;
      end
   end

   // sticky events, write one to clear; an event in the clearing cycle stays set
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         irq_stat_reg <= qsp_pkg::IRQ_RST;
         irq_mask_reg <= qsp_pkg::IRQ_RST;
      end else if (CLK_EN) begin
         if (done && AVS_WRITE && hit && roff == qsp_pkg::OFF_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~(AVS_WRITEDATA[11:0] & wmask[11:0])) | ev_all;
         else
            irq_stat_reg <= irq_stat_reg | ev_all;
         if (done && AVS_WRITE && hit && roff == qsp_pkg::OFF_IRQ_MASK)
            irq_mask_reg <= (irq_mask_reg & ~wmask[11:0]) | (AVS_WRITEDATA[11:0] & wmask[11:0]);
      end
   end
   assign irq_any = |(irq_stat_reg & irq_mask_reg);
   // jumper value n puts the request on line n-1, zero leaves every line quiet
   always_comb begin
      for (int i = 0; i < IRQ_LEVELS; i++)
         IRQ_LINES[i] = irq_any && (INTERRUPT_LEVEL_JUMPER == 3'(i + 1));
   end

   // per-port copies of rate select, control, handshake and indicators
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic sel_hit;
      logic tled_reg, rled_reg;
      assign sel_hit = done && port_hit && (pidx == 2'(p));
      // exactly one switch closed gives a clock; none or several stop the adapter
      assign tick[p] = $onehot(RATE_SELECT_SWITCH[p*6 +: 6])
                       && |(RATE_SELECT_SWITCH[p*6 +: 6] & tap_rise);
      always_ff @(posedge CLOCK) begin
         if (SYS_RST)
            ctrl_reg[p] <= qsp_pkg::CTRL_RST;
         else if (CLK_EN && sel_hit && AVS_WRITE && AVS_BYTEENABLE[0]
                  && {4'h0, roff[3:0]} == qsp_pkg::OFF_CTRL)
            ctrl_reg[p] <= AVS_WRITEDATA[5:0];
      end
      assign port_bus[p].ref_tick = tick[p];
      assign port_bus[p].ctrl     = ctrl_reg[p];
      assign port_bus[p].tx_byte  = AVS_WRITEDATA[7:0];
      assign port_bus[p].tx_wr    = sel_hit && AVS_WRITE && AVS_BYTEENABLE[0]
                                    && {4'h0, roff[3:0]} == qsp_pkg::OFF_DATA;
      assign port_bus[p].rx_rd    = sel_hit && AVS_READ
                                    && {4'h0, roff[3:0]} == qsp_pkg::OFF_DATA;
      assign ev_all[p*3 +: 3]     = port_bus[p].events;
      assign stat_all[p]          = port_bus[p].status;
      assign rxb_all[p]           = port_bus[p].rx_byte;
      assign RTS_N[p]             = !ctrl_reg[p][qsp_pkg::CTRL_RTS];
      // indicators lit while the line is at space
      always_ff @(posedge CLOCK) begin
         if (SYS_RST) begin
            tled_reg <= 1'b0;
            rled_reg <= 1'b0;
         end else if (CLK_EN) begin
            tled_reg <= !TXD[p];
            rled_reg <= !RXD[p];
         end
      end
      assign TX_LED[p] = tled_reg;
      assign RX_LED[p] = rled_reg;
      qsp_adapter u_adapter (
         .clk   (CLOCK),
         .rst   (SYS_RST),
         .ce    (CLK_EN),
         .bus   (port_bus[p]),
         .txd   (TXD[p]),
         .rxd   (RXD[p]),
         .cts_n (CTS_N[p]),
         .dcd_n (DCD_N[p])
      );
   end
   for (genvar e = NUM_PORTS * 3; e < 12; e++) begin : g_noev
      assign ev_all[e] = 1'b0;
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   irq_none_a: assert property ((INTERRUPT_LEVEL_JUMPER == 3'h0) |-> (IRQ_LINES == '0))
      else $error("interrupt driven with no level selected");
   irq_level_a: assert property ((irq_any && INTERRUPT_LEVEL_JUMPER == 3'h1) |-> IRQ_LINES[0])
      else $error("interrupt missing on the selected level");
   rts_cmd_a: assert property ($changed(RTS_N[0]) |-> $past(done && AVS_WRITE && port_hit && pidx == 2'h0))
      else $error("request-to-send moved without a control write");
   base_ctrl_a: assert property ((done && AVS_WRITE && AVS_BYTEENABLE[0] && BOARD_ADDRESS_SWITCH == 2'h0 && BLOCK_BASE_SWITCH == 2'h3 && AVS_ADDRESS == 16'h8340) |=> ctrl_reg[0] == $past(AVS_WRITEDATA[5:0]))
      else $error("control write at the switched base not taken");
   ref_tick_a: assert property (tick[0] |-> $onehot(RATE_SELECT_SWITCH[5:0]) && xtal_tick)
      else $error("reference tick without a single selected tap");
   bus_answer_a: assert property ((req && !ack_reg && CLK_EN) |=> (!AVS_WAITREQUEST || !CLK_EN))
      else $error("bus request not answered after one wait state");
endmodule
`default_nettype wire
